// *** hw/tbt_top.sv ***
// Purpose: periodic time base timer with an AXI4-Lite control slave
// Assumes: hfTick and lfTick are one-cycle pulses synchronous to clk_sys
// Notes:   tick request is a one-cycle pulse; interrupt control lives elsewhere
`timescale 1ns/10ps
`default_nettype none
module tbt_top #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              hfTick,
    input  wire logic              lfTick,
    input  wire logic              lowSpeedMode,
    output logic                   periodicTickInterrupt,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // write channel holding state
    logic              awHeld_r,  awHeld_nxt;  // write address taken, not yet used
    logic [ADDR_W-1:0] awAddr_r,  awAddr_nxt;  // taken write address
    logic              wHeld_r,   wHeld_nxt;   // write data taken, not yet used
    logic [31:0]       wData_r,   wData_nxt;   // taken write data
    logic [3:0]        wStrb_r,   wStrb_nxt;   // taken byte enables
    logic              bValid_r,  bValid_nxt;  // write answer pending
    logic [1:0]        bResp_r,   bResp_nxt;   // write answer code
    // read channel state
    logic              rValid_r,  rValid_nxt;  // read answer pending
    logic [31:0]       rData_r,   rData_nxt;   // read answer data
    logic [1:0]        rResp_r,   rResp_nxt;   // read answer code
    // timer state
    tbt_pkg::tbt_ctrl_s ctrl_r,   ctrl_nxt;    // control register
    logic              irq_r,     irq_nxt;     // registered tick request
    // prescaler view
    logic [tbt_pkg::DIV_WIDTH-1:0] divCount;   // stage levels
    logic [tbt_pkg::DIV_WIDTH-1:0] divFall;    // stage falling pulses
    logic              lowSrc;                 // low clock feeds the prescaler
    logic              rateValid;              // code has a defined rate here
    logic [4:0]        tapSel;                 // selected stage
    logic              doWrite;                // both halves of a write held
    logic              ctrlWrite;              // control byte written this cycle

    // low-speed modes always run the prescaler from the low clock
    assign lowSrc    = lowSpeedMode | ctrl_r.dividerSourceSelect;
    assign tapSel    = tbt_pkg::tapIndex(ctrl_r.interruptRateSelect, lowSrc);
    // codes above 001 have no rate in slow modes; they simply stay silent
    assign rateValid = !lowSpeedMode
                       || ctrl_r.interruptRateSelect <= tbt_pkg::SLOW_RATE_MAX;

    // one prescaler, stepped by whichever source is selected
    tbt_prescaler #(
        .WIDTH   (tbt_pkg::DIV_WIDTH)
    ) u_prescaler (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .advance (lowSrc ? lfTick : hfTick),
        .count   (divCount),
        .fallVec (divFall)
    );

    assign doWrite   = awHeld_r && wHeld_r && !bValid_r;
    assign ctrlWrite = doWrite && wStrb_r[0]
                       && tbt_pkg::addrHits(awAddr_r, tbt_pkg::CTRL_INDEX);

    // write side: address and data are taken independently, then applied together
    always_comb begin
        awHeld_nxt = awHeld_r;
        awAddr_nxt = awAddr_r;
        wHeld_nxt  = wHeld_r;
        wData_nxt  = wData_r;
        wStrb_nxt  = wStrb_r;
        bValid_nxt = bValid_r;
        bResp_nxt  = bResp_r;
        // address handshake
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_nxt = 1'b1;
            awAddr_nxt = s_axi_awaddr;
        end
        // data handshake
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_nxt = 1'b1;
            wData_nxt = s_axi_wdata;
            wStrb_nxt = s_axi_wstrb;
        end
        // apply and answer; status word is read only and answers okay
        if (doWrite) begin
            awHeld_nxt = 1'b0;
            wHeld_nxt  = 1'b0;
            bValid_nxt = 1'b1;
            if (tbt_pkg::addrHits(awAddr_r, tbt_pkg::CTRL_INDEX)
                || tbt_pkg::addrHits(awAddr_r, tbt_pkg::STATUS_INDEX)) begin
                bResp_nxt = tbt_pkg::RESP_OKAY;
            end else begin
                bResp_nxt = tbt_pkg::RESP_SLVERR;
            end
        end else if (bValid_r && s_axi_bready) begin
            bValid_nxt = 1'b0;
        end
    end

    // control register: rate and enable may load in the same write
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrlWrite) begin
            // rate is taken as written; keeping it steady while running is software's job
            ctrl_nxt.interruptRateSelect = wData_r[tbt_pkg::RATE_LSB +: 3];
            ctrl_nxt.periodicTimerEnable = wData_r[tbt_pkg::ENABLE_BIT];
            ctrl_nxt.dividerSourceSelect = wData_r[tbt_pkg::SRC_BIT];
        end
    end

    // read side: one answer at a time, data from flops
    always_comb begin
        rValid_nxt = rValid_r;
        rData_nxt  = rData_r;
        rResp_nxt  = rResp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_nxt = 1'b1;
            rData_nxt  = 32'h0000_0000;
            rResp_nxt  = tbt_pkg::RESP_OKAY;
            if (tbt_pkg::addrHits(s_axi_araddr, tbt_pkg::CTRL_INDEX)) begin
                rData_nxt[4:0] = ctrl_r;
            end else if (tbt_pkg::addrHits(s_axi_araddr, tbt_pkg::STATUS_INDEX)) begin
                // live tap level, rate validity and source in use
                rData_nxt[2:0] = {lowSrc, rateValid, divCount[tapSel]};
            end else begin
                rResp_nxt = tbt_pkg::RESP_SLVERR;
            end
        end else if (rValid_r && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end
    end

    // tick request on each falling edge of the selected stage while enabled and the rate code is valid
    always_comb begin
        irq_nxt = ctrl_r.periodicTimerEnable && rateValid && divFall[tapSel];
    end

    // register every group of state; reset leaves the timer disabled
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
            wHeld_r  <= 1'b0;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r  <= tbt_pkg::RESP_OKAY;
            rValid_r <= 1'b0;
            rData_r  <= 32'h0000_0000;
            rResp_r  <= tbt_pkg::RESP_OKAY;
            ctrl_r   <= tbt_pkg::tbt_ctrl_s'(tbt_pkg::CTRL_RESET[4:0]);
            irq_r    <= 1'b0;
        end else begin
            awHeld_r <= awHeld_nxt;
            awAddr_r <= awAddr_nxt;
            wHeld_r  <= wHeld_nxt;
            wData_r  <= wData_nxt;
            wStrb_r  <= wStrb_nxt;
            bValid_r <= bValid_nxt;
            bResp_r  <= bResp_nxt;
            rValid_r <= rValid_nxt;
            rData_r  <= rData_nxt;
            rResp_r  <= rResp_nxt;
            ctrl_r   <= ctrl_nxt;
            irq_r    <= irq_nxt;
        end
    end

    // handshake outputs are combinational, data from flops
    assign s_axi_awready         = !awHeld_r;
    assign s_axi_wready          = !wHeld_r;
    assign s_axi_bvalid          = bValid_r;
    assign s_axi_bresp           = bResp_r;
    assign s_axi_arready         = !rValid_r;
    assign s_axi_rvalid          = rValid_r;
    assign s_axi_rdata           = rData_r;
    assign s_axi_rresp           = rResp_r;
    assign periodicTickInterrupt = irq_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // a control write that is applied this cycle
    sequence s_ctrlWrite;
        ctrlWrite;
    endsequence

    // an enabled, valid falling edge of the chosen stage
    sequence s_tapFall;
        ctrl_r.periodicTimerEnable && rateValid && divFall[tapSel];
    endsequence

    property p_tickOnFall;
        s_tapFall |=> periodicTickInterrupt;
    endproperty
    a_tickOnFall: assert property (p_tickOnFall)
        else $error("no tick after selected stage fell");

    property p_tickHasCause;
        periodicTickInterrupt |-> $past(ctrl_r.periodicTimerEnable)
                                  && $past(divFall[tapSel]);
    endproperty
    a_tickHasCause: assert property (p_tickHasCause)
        else $error("tick without enable or falling stage");

    property p_noClearOnWrite;
        s_ctrlWrite ##0 !(lowSrc ? lfTick : hfTick) |=> $stable(divCount);
    endproperty
    a_noClearOnWrite: assert property (p_noClearOnWrite)
        else $error("prescaler moved on a control write");

    property p_loadTogether;
        s_ctrlWrite |=> ctrl_r == $past(wData_r[4:0]);
    endproperty
    a_loadTogether: assert property (p_loadTogether)
        else $error("rate and enable not loaded together");

    property p_tapMap;
        !lowSrc && ctrl_r.interruptRateSelect == 3'h2 |-> tapSel == 5'd15;
    endproperty
    a_tapMap: assert property (p_tapMap)
        else $error("code 010 not on stage 15");

    property p_slowSilent;
        lowSpeedMode && ctrl_r.interruptRateSelect > 3'h1 |=> !periodicTickInterrupt;
    endproperty
    a_slowSilent: assert property (p_slowSilent)
        else $error("tick for undefined slow rate");

    property p_disabledQuiet;
        !ctrl_r.periodicTimerEnable [*2] |=> !periodicTickInterrupt;
    endproperty
    a_disabledQuiet: assert property (p_disabledQuiet)
        else $error("tick while disabled");

    property p_writeAnswer;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_writeAnswer: assert property (p_writeAnswer)
        else $error("write answer dropped early");

    property p_readAnswer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_readAnswer: assert property (p_readAnswer)
        else $error("read answer late");

endmodule : tbt_top
`default_nettype wire

// *** pkg/tbt_pkg.sv ***
// Purpose: constants, types and decode helpers of the periodic time base timer
// Assumes: registers sit in the low byte of 32-bit AXI4-Lite words
// Notes:   printed offsets are register indices; byte address is four times the index
//
// Contract
// - tick request on every falling edge of tap
// - prescaler never cleared by enable or write
// - rate and enable load in one write
// - rate code picks one of eight taps
// - slow modes allow only codes 000, 001
package tbt_pkg;

    localparam int unsigned CTRL_INDEX    = 32'h0000_0036; // printed control offset
    localparam int unsigned STATUS_INDEX  = 32'h0000_0037; // status word index
    localparam logic [7:0]  CTRL_RESET    = 8'h00;         // control after reset
    localparam int unsigned RATE_LSB      = 0;             // rate select field low bit
    localparam int unsigned ENABLE_BIT    = 3;             // timer enable bit
    localparam int unsigned SRC_BIT       = 4;             // divider source select bit
    localparam int unsigned DIV_WIDTH     = 23;            // prescaler stages
    localparam logic [1:0]  RESP_OKAY     = 2'h0;          // axi okay answer
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;          // axi answer for unmapped word
    localparam logic [2:0]  SLOW_RATE_MAX = 3'h1;          // highest code legal in slow modes

    // software-visible control fields
    typedef struct packed {
        logic       dividerSourceSelect; // low frequency source in normal modes
        logic       periodicTimerEnable; // timer running
        logic [2:0] interruptRateSelect; // tap code
    } tbt_ctrl_s;

    // true when a byte address lands on the word of a register index
    function automatic logic addrHits(input logic [7:0] addr, input int unsigned idx);
        logic [7:0] want;
        want = 8'(idx * 4);
        return addr[7:2] == want[7:2];
    endfunction : addrHits

    // stage of the prescaler whose falling edge paces the requests
    function automatic logic [4:0] tapIndex(input logic [2:0] code, input logic lowSrc);
        logic [4:0] hi;
        case (code)
            3'h0:    hi = 5'd22;
            3'h1:    hi = 5'd20;
            3'h2:    hi = 5'd15;
            3'h3:    hi = 5'd13;
            3'h4:    hi = 5'd12;
            3'h5:    hi = 5'd11;
            3'h6:    hi = 5'd10;
            default: hi = 5'd8;
        endcase
        // the low clock taps sit eight stages lower
        return lowSrc ? hi - 5'd8 : hi;
    endfunction : tapIndex

endpackage : tbt_pkg

// *** hw/tbt_prescaler.sv ***
// Purpose: free-running binary prescaler with per-stage falling edge pulses
// Assumes: advance is a one-cycle enable per source clock period
// Notes:   no clear input at all, so software can never restart it
`timescale 1ns/10ps
`default_nettype none
module tbt_prescaler #(
    parameter int unsigned WIDTH = tbt_pkg::DIV_WIDTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             advance,
    output logic [WIDTH-1:0]      count,
    output logic [WIDTH-1:0]      fallVec
);

    logic [WIDTH-1:0] count_r;   // stage levels
    logic [WIDTH-1:0] count_nxt; // levels after this cycle

    // next count; only the source enable moves it
    always_comb begin
        count_nxt = count_r;
        if (advance) begin
            count_nxt = count_r + WIDTH'(1);
        end
    end

    // register the stages
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // a stage falls when it is high now and low after the increment
    assign fallVec = count_r & ~count_nxt;
    assign count   = count_r;

endmodule : tbt_prescaler
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the periodic time base timer and its control slave
// Assumes: hfTick pulses every cycle, lfTick every second cycle, so lf periods double
// Notes:   the longest rate codes are not timed; they would dwarf the run length
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [7:0] CTRL_ADDR = 8'(tbt_pkg::CTRL_INDEX * 4);   // control word
    localparam logic [7:0] STAT_ADDR = 8'(tbt_pkg::STATUS_INDEX * 4); // status word
    localparam logic [7:0] HOLE_ADDR = 8'h10;                          // nothing mapped here
    localparam int         LIMIT     = 90000;                          // run ceiling in cycles

    logic        clk_sys       = 1'b0;  // 100 MHz system clock
    logic        rst_b         = 1'b0;  // held low for ten cycles
    logic        hfTick        = 1'b1;  // high clock pulse, every cycle
    logic        lfTick        = 1'b0;  // low clock pulse, every second cycle
    logic        lowSpeedMode  = 1'b0;  // slow and sleep modes
    logic        periodicTickInterrupt;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata   = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb   = 4'hF;  // byte enables, lane 0 carries control
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready  = 1'b0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready  = 1'b0;
    int          errors        = 0;     // mismatches
    int          compares      = 0;     // comparisons made
    int          cyc           = 0;     // free cycle stamp
    int          tickCnt       = 0;     // requests seen
    int          tickAt        = 0;     // stamp of the latest request
    int          hfExp [8]     = '{23, 21, 16, 14, 13, 12, 11, 9}; // high source divide powers
    int          lfExp [8]     = '{15, 13, 8, 6, 5, 4, 3, 1};      // low source divide powers

    tbt_top dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .hfTick(hfTick), .lfTick(lfTick),
        .lowSpeedMode(lowSpeedMode), .periodicTickInterrupt(periodicTickInterrupt),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    // clock, half period 5 ns
    always #5 clk_sys = ~clk_sys;

    // low clock pulses run free, also through reset
    always @(posedge clk_sys) begin
        lfTick <= ~lfTick;
    end

    // stamps every request and cuts a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (periodicTickInterrupt === 1'b1) begin
            tickCnt <= tickCnt + 1;
            tickAt  <= cyc;
        end
        if (cyc == LIMIT) begin
            errors++;
            $display("unexpected run limit at %0t", $time);
            final_report();
        end
    end

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected word at %0t: got %h want %h", $time, got, exp);
        end
    endtask : checkWord

    task automatic checkResp(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected response at %0t: got %h want %h", $time, got, exp);
        end
    endtask : checkResp

    task automatic checkCount(input int got, input int exp);
        compares++;
        if (got != exp) begin
            errors++;
            $display("unexpected count at %0t: got %0d want %0d", $time, got, exp);
        end
    endtask : checkCount

    // address and data offered together, each dropped on its own handshake
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 50) begin
            errors++;
            $display("unexpected write timeout at %0t", $time);
        end
        // one idle edge, so a following call never re-raises bready in this step
        @(posedge clk_sys);
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 50) begin
            errors++;
            $display("unexpected read timeout at %0t", $time);
        end
        // one idle edge, so a following call never re-raises rready in this step
        @(posedge clk_sys);
    endtask : axiRead

    // waits for the next request, gap is cycles since the one before
    task automatic waitTick(input int lim, output int gap);
        int c0;
        int prev;
        int n;
        c0   = tickCnt;
        prev = tickAt;
        n    = 0;
        while (tickCnt == c0 && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        if (tickCnt == c0) begin
            errors++;
            $display("unexpected missing tick at %0t", $time);
        end
        gap = tickAt - prev;
    endtask : waitTick

    // rate and enable in one write, then one full period is timed
    task automatic runRate(input logic src, input logic [2:0] code, input int expP);
        logic [1:0] rsp;
        int         gap;
        axiWrite(CTRL_ADDR, {27'h0, src, 1'b1, code}, rsp);
        waitTick(expP + 64, gap);
        waitTick(expP + 64, gap);
        checkCount(gap, expP);
        axiWrite(CTRL_ADDR, {27'h0, src, 1'b0, code}, rsp);
    endtask : runRate

    task automatic final_report;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    initial begin
        logic [31:0] rd;
        logic [1:0]  rsp;
        int          n;
        int          gap;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        axiRead(CTRL_ADDR, rd, rsp);
        checkWord(rd, 32'h0000_0000);
        // unmapped word answers with an error and no data
        axiRead(HOLE_ADDR, rd, rsp);
        checkResp(rsp, tbt_pkg::RESP_SLVERR);
        checkWord(rd, 32'h0000_0000);
        axiWrite(HOLE_ADDR, 32'hFFFF_FFFF, rsp);
        checkResp(rsp, tbt_pkg::RESP_SLVERR);
        // fields read back, upper bits stay zero, timer still off
        axiWrite(CTRL_ADDR, 32'hFFFF_FFF7, rsp);
        checkResp(rsp, tbt_pkg::RESP_OKAY);
        axiRead(CTRL_ADDR, rd, rsp);
        checkWord(rd, 32'h0000_0017);
        // lane 0 disabled and the read-only status word both leave control alone
        s_axi_wstrb <= 4'h0;
        axiWrite(CTRL_ADDR, 32'h0000_0000, rsp);
        s_axi_wstrb <= 4'hF;
        checkResp(rsp, tbt_pkg::RESP_OKAY);
        axiWrite(STAT_ADDR, 32'hFFFF_FFFF, rsp);
        checkResp(rsp, tbt_pkg::RESP_OKAY);
        axiRead(CTRL_ADDR, rd, rsp);
        checkWord(rd, 32'h0000_0017);
        n = tickCnt;
        repeat (200) @(posedge clk_sys);
        checkCount(tickCnt - n, 0);
        for (int i = 4; i < 8; i++) runRate(1'b0, i[2:0], 2 ** hfExp[i]);
        for (int i = 2; i < 8; i++) runRate(1'b1, i[2:0], 2 * 2 ** lfExp[i]);
        // a pause in mid-period must not restart the divider
        axiWrite(CTRL_ADDR, 32'h0000_000F, rsp);
        waitTick(600, gap);
        axiWrite(CTRL_ADDR, 32'h0000_0007, rsp);
        repeat (100) @(posedge clk_sys);
        axiWrite(CTRL_ADDR, 32'h0000_000F, rsp);
        waitTick(600, gap);
        checkCount(gap, 512);
        axiWrite(CTRL_ADDR, 32'h0000_0007, rsp);
        // normal mode, code 010 from the high clock is a valid rate
        axiWrite(CTRL_ADDR, 32'h0000_0002, rsp);
        axiRead(STAT_ADDR, rd, rsp);
        checkWord(rd & 32'h0000_0006, 32'h0000_0002);
        // slow mode: undefined code stays silent, code 001 runs from the low clock
        lowSpeedMode <= 1'b1;
        axiWrite(CTRL_ADDR, 32'h0000_000A, rsp);
        axiRead(STAT_ADDR, rd, rsp);
        checkWord(rd & 32'h0000_0006, 32'h0000_0004);
        n = tickCnt;
        repeat (600) @(posedge clk_sys);
        checkCount(tickCnt - n, 0);
        axiWrite(CTRL_ADDR, 32'h0000_0002, rsp);
        runRate(1'b0, 3'h1, 2 * 2 ** lfExp[1]);
        final_report();
    end
endmodule : testbench
`default_nettype wire
